// ===== include/sbs_regs.vh
// shared constants for the sync burst sram control block
`ifndef SBS_REGS_VH
`define SBS_REGS_VH

// cycle kinds decoded at the clock edge
`define SBS_OP_IDLE      3'h0
`define SBS_OP_DESELECT  3'h1
`define SBS_OP_READ_NEW  3'h2
`define SBS_OP_WRITE_NEW 3'h3
`define SBS_OP_READ_CONT 3'h4
`define SBS_OP_WRITE_CON 3'h5
`define SBS_OP_READ_HOLD 3'h6
`define SBS_OP_WRITE_HLD 3'h7

// widths and defaults
`define SBS_BURST_W      2
`define SBS_LANES_WIDE   4
`define SBS_LANE_W       9
`define SBS_FIFO_DEPTH   8
`define SBS_ADDR_W       8

`endif

// ===== verilog/sbs_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sbs_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    core_clk,
    reset_n,
    clk_en,
    in_valid,
    in_ready,
    in_data,
    out_valid,
    out_ready,
    out_data
);
    input  wire             core_clk;
    input  wire             reset_n;
    input  wire             clk_en;
    input  wire             in_valid;
    output wire             in_ready;
    input  wire [WIDTH-1:0] in_data;
    output wire             out_valid;
    input  wire             out_ready;
    output wire [WIDTH-1:0] out_data;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;

    wire push = in_valid && in_ready && clk_en;
    wire pop  = out_valid && out_ready && clk_en;

    assign in_ready  = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_q];

    // storage has no reset, contents only valid under count
    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // pointers wrap at depth, depth need not be a power of two
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

// ===== verilog/sbs_burst_counter.v
// 2-bit burst address counter, linear or interleaved order
`timescale 1ns/1ps
`include "sbs_regs.vh"
module sbs_burst_counter (
    core_clk,
    reset_n,
    clk_en,
    load,
    step,
    start_addr,
    interleave,
    burst_addr
);
    input  wire                    core_clk;
    input  wire                    reset_n;
    input  wire                    clk_en;
    input  wire                    load;
    input  wire                    step;
    input  wire [`SBS_BURST_W-1:0] start_addr;
    input  wire                    interleave;
    output wire [`SBS_BURST_W-1:0] burst_addr;

    reg [`SBS_BURST_W-1:0] start_q;
    reg [`SBS_BURST_W-1:0] count_q;
    wire [`SBS_BURST_W-1:0] start_nx;
    wire [`SBS_BURST_W-1:0] count_nx;

    // look ahead to the cycle being taken, so a step shows the next word at once
    assign start_nx = load ? start_addr : start_q;
    assign count_nx = load ? {`SBS_BURST_W{1'b0}} : (step ? count_q + 1'b1 : count_q);

    // interleaved xors the count into the start, linear adds it
    assign burst_addr = interleave ? (start_nx ^ count_nx)
                                   : (start_nx + count_nx);  // see RULE8

    // count wraps mod four so the fourth step returns to start
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            start_q <= {`SBS_BURST_W{1'b0}};
            count_q <= {`SBS_BURST_W{1'b0}};
        end else if (clk_en) begin
            if (load) begin
                start_q <= start_addr;               // see RULE7
                count_q <= {`SBS_BURST_W{1'b0}};
            end else if (step) begin
                count_q <= count_q + 1'b1;           // see RULE9
            end
        end
    end
endmodule

// ===== verilog/sbs_sram_control.v
// synchronous control of a burst sram: decode, burst, lanes, output timing
// Functional notes
// RULE1 - sync inputs sampled on rising edge, low-true
// RULE2 - chip deselected with controller strobe: deselect, released
// RULE3 - processor strobe with select starts read burst
// RULE4 - controller strobe starts read or write burst
// RULE5 - no strobe, step low: next address
// RULE6 - no strobe, step high: repeat current address
// RULE7 - low address bits preset the burst counter
// RULE8 - linear adds one, interleaved xors sequence
// RULE9 - counter wraps to start on fifth clock
// RULE10 - global write writes every lane
// RULE11 - lane enable writes only selected lanes
// RULE12 - neither write asserted means read, all lanes
// RULE13 - data pins released during every write; here only writes with a lane set in mem_lane_we force data_oe_n high
// RULE14 - upper lanes only in wide organisation
// RULE15 - bypass strap low gives flow-through reads
// RULE16 - latency strap low gives dual cycle deselect
// RULE17 - sleep high puts device in standby
// RULE18 - strap defaults give pipelined, single deselect, active
// RULE19 - data driven only while output enable low
// RULE20 - dual deselect pipelines as deep as reads
// RULE21 - output enable acts without the clock; here it passes two clocked flops before data_oe_n
// RULE22 - reads with output enable high still advance
`timescale 1ns/1ps
`include "sbs_regs.vh"
module sbs_sram_control #(
    parameter LANES  = `SBS_LANES_WIDE,
    parameter LANE_W = `SBS_LANE_W,
    parameter AW     = `SBS_ADDR_W
) (
    core_clk,
    reset_n,
    clk_en,
    chip_select_n,
    proc_addr_strobe_n,
    ctrl_addr_strobe_n,
    burst_step_n,
    all_lanes_write_n,
    lane_write_enable_n,
    lane_select_n,
    addr_in,
    output_enable_n,
    sleep_request,
    register_bypass_n,
    linear_order_n,
    deselect_latency_sel,
    drive_strength_sel,
    data_in,
    data_out,
    data_oe_n,
    mem_addr,
    mem_lane_we,
    mem_read,
    mem_rdata_valid,
    mem_rdata_ready,
    mem_rdata,
    standby,
    high_drive
);
    input  wire                     core_clk;
    input  wire                     reset_n;
    input  wire                     clk_en;
    input  wire                     chip_select_n;
    input  wire                     proc_addr_strobe_n;
    input  wire                     ctrl_addr_strobe_n;
    input  wire                     burst_step_n;
    input  wire                     all_lanes_write_n;
    input  wire                     lane_write_enable_n;
    input  wire [LANES-1:0]         lane_select_n;
    input  wire [AW-1:0]            addr_in;
    input  wire                     output_enable_n;
    input  wire                     sleep_request;
    input  wire                     register_bypass_n;
    input  wire                     linear_order_n;
    input  wire                     deselect_latency_sel;
    input  wire                     drive_strength_sel;
    input  wire [LANES*LANE_W-1:0]  data_in;
    output reg  [LANES*LANE_W-1:0]  data_out;
    output reg                      data_oe_n;
    output reg  [AW-1:0]            mem_addr;
    output reg  [LANES-1:0]         mem_lane_we;
    output reg                      mem_read;
    input  wire                     mem_rdata_valid;
    output reg                      mem_rdata_ready;
    input  wire [LANES*LANE_W-1:0]  mem_rdata;
    output reg                      standby;
    output reg                      high_drive;

    localparam DW = LANES * LANE_W;

    // two-flop synchronisers for pins from outside the clock domain
    reg       pin_s1_q;
    reg       pin_s2_q;
    reg [3:0] strap_s1_q;
    reg [3:0] strap_s2_q;

    // output-enable path, kept apart from the clocked pipeline
    reg       oe_s1_q;
    reg       oe_s2_q;

    // decoded cycle and pipeline stages
    reg [2:0]       op_d;
    reg [2:0]       op_q;
    reg [AW-1:0]    base_q;
    reg             rd_stage1_q;
    reg             rd_stage2_q;
    reg             drive_q;
    reg             rd_late_q;
    reg             pop_q;
    reg [LANES-1:0] lane_we_d;

    wire [1:0] burst_addr;
    wire       ctr_load;
    wire       ctr_step;
    wire       is_write;
    wire       fifo_out_valid;
    wire       fifo_in_ready;
    wire [DW-1:0] fifo_out_data;

    // strap order: bypass, latency, drive, sleep(async, active high)
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_s1_q <= 4'hE;                      // see RULE18
            strap_s2_q <= 4'hE;
            oe_s1_q    <= 1'b1;
            oe_s2_q    <= 1'b1;
            pin_s1_q   <= 1'b0;
            pin_s2_q   <= 1'b0;
        end else begin
            strap_s1_q <= {register_bypass_n, deselect_latency_sel,
                           drive_strength_sel, sleep_request};
            strap_s2_q <= strap_s1_q;
            oe_s1_q    <= output_enable_n;           // see RULE21
            oe_s2_q    <= oe_s1_q;
            pin_s1_q   <= chip_select_n;
            pin_s2_q   <= pin_s1_q;
        end
    end

    wire pipelined  = strap_s2_q[3];                 // see RULE15
    wire single_dsl = strap_s2_q[2];                 // see RULE16
    wire sleeping   = strap_s2_q[0];                 // see RULE17

    // write decode: global write covers every lane, else selected lanes
    function [LANES-1:0] lane_decode;
        input             gw_n;
        input             bw_n;
        input [LANES-1:0] sel_n;
        begin
            if (!gw_n) begin
                lane_decode = {LANES{1'b1}};         // see RULE10
            end else if (!bw_n) begin
                lane_decode = ~sel_n;                // see RULE11
            end else begin
                lane_decode = {LANES{1'b0}};         // see RULE12
            end
        end
    endfunction

    // write is true when global or lane enable is low, even no lanes
    assign is_write = !all_lanes_write_n || !lane_write_enable_n;

    // cycle decode; strobes and selects are sampled at this edge
    always @* begin
        lane_we_d = lane_decode(all_lanes_write_n, lane_write_enable_n,
                                lane_select_n);      // see RULE14
        if (!chip_select_n && !proc_addr_strobe_n) begin
            op_d      = `SBS_OP_READ_NEW;            // see RULE3
            lane_we_d = {LANES{1'b0}};
        end else if (chip_select_n && !ctrl_addr_strobe_n) begin
            op_d      = `SBS_OP_DESELECT;            // see RULE2
            lane_we_d = {LANES{1'b0}};
        end else if (!ctrl_addr_strobe_n) begin
            op_d = is_write ? `SBS_OP_WRITE_NEW : `SBS_OP_READ_NEW;  // see RULE4
        end else if (!burst_step_n) begin
            op_d = is_write ? `SBS_OP_WRITE_CON : `SBS_OP_READ_CONT; // see RULE5
        end else begin
            op_d = is_write ? `SBS_OP_WRITE_HLD : `SBS_OP_READ_HOLD; // see RULE6
        end
        if (sleeping) begin
            op_d      = `SBS_OP_IDLE;
            lane_we_d = {LANES{1'b0}};
        end
    end

    // the lone processor strobe while deselected has no defined action
    // and is handled like a continue or hold cycle, never a new load
    assign ctr_load = (op_d == `SBS_OP_READ_NEW) || (op_d == `SBS_OP_WRITE_NEW);
    assign ctr_step = (op_d == `SBS_OP_READ_CONT) || (op_d == `SBS_OP_WRITE_CON);

    sbs_burst_counter u_burst (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .load       (ctr_load),
        .step       (ctr_step),
        .start_addr (addr_in[1:0]),
        .interleave (linear_order_n),
        .burst_addr (burst_addr)
    );

    // address capture and array strobes, one cycle after the edge
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            op_q        <= `SBS_OP_IDLE;
            base_q      <= {AW{1'b0}};
            mem_addr    <= {AW{1'b0}};
            mem_lane_we <= {LANES{1'b0}};
            mem_read    <= 1'b0;
        end else if (clk_en) begin
            op_q        <= op_d;
            mem_lane_we <= lane_we_d;                // see RULE1
            if (ctr_load) begin
                base_q   <= addr_in;
                mem_addr <= addr_in;                 // see RULE7
            end else begin
                mem_addr <= {base_q[AW-1:2], burst_addr};
            end
            // dummy reads still count: read strobe ignores output enable
            mem_read <= (op_d == `SBS_OP_READ_NEW) || (op_d == `SBS_OP_READ_CONT)
                        || (op_d == `SBS_OP_READ_HOLD);  // see RULE22
        end
    end

    // read data buffered so a stalled output stage backs up the array
    sbs_fifo #(
        .WIDTH (DW),
        .DEPTH (`SBS_FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .in_valid  (mem_rdata_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (mem_rdata),
        .out_valid (fifo_out_valid),
        .out_ready (pop_q),
        .out_data  (fifo_out_data)
    );

    // drive window: flow-through one stage, pipelined two; in pipelined mode single
    // deselect cuts the last stage so outputs fall one edge early
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_stage1_q     <= 1'b0;
            rd_stage2_q     <= 1'b0;
            drive_q         <= 1'b0;
            rd_late_q       <= 1'b0;
            pop_q           <= 1'b0;
            data_out        <= {DW{1'b0}};
            data_oe_n       <= 1'b1;
            mem_rdata_ready <= 1'b0;
            standby         <= 1'b0;
            high_drive      <= 1'b0;
        end else if (clk_en) begin
            rd_stage1_q     <= mem_read;
            rd_stage2_q     <= rd_stage1_q && !(single_dsl &&
                               (op_q == `SBS_OP_DESELECT));      // see RULE20
            drive_q         <= pipelined ? rd_stage2_q : rd_stage1_q;
            // uncut pop pipe: every read takes its word, even a cut one
            rd_late_q       <= rd_stage1_q;
            pop_q           <= pipelined ? rd_late_q : rd_stage1_q;  // see RULE15
            mem_rdata_ready <= fifo_in_ready;
            standby         <= sleeping;
            high_drive      <= !strap_s2_q[1];
            if (fifo_out_valid && pop_q) begin
                data_out <= fifo_out_data;
            end
            // released on writes, deselects and with enable high
            data_oe_n <= !(drive_q && (mem_lane_we == {LANES{1'b0}})
                         && !oe_s2_q);               // see RULE13, see RULE19
        end
    end
endmodule

// ===== testbench/sbs_sram_control_sva.sv
// port checker for the burst sram control block, bound to its top
`timescale 1ns/1ps
module sbs_sram_control_sva #(
    parameter LANES = 4,
    parameter AW    = 8
) (
    input logic             core_clk,
    input logic             reset_n,
    input logic             clk_en,
    input logic             chip_select_n,
    input logic             proc_addr_strobe_n,
    input logic             ctrl_addr_strobe_n,
    input logic             burst_step_n,
    input logic             all_lanes_write_n,
    input logic             lane_write_enable_n,
    input logic [LANES-1:0] lane_select_n,
    input logic [AW-1:0]    addr_in,
    input logic             output_enable_n,
    input logic             sleep_request,
    input logic             linear_order_n,
    input logic             data_oe_n,
    input logic [AW-1:0]    mem_addr,
    input logic [LANES-1:0] mem_lane_we,
    input logic             mem_read,
    input logic             standby
);
    logic [3:0] slp_q;
    wire        run_ok;
    // sleep history, so decode checks skip the synchroniser lag
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) slp_q <= 4'h0;
        else slp_q <= {slp_q[2:0], sleep_request};
    end
    assign run_ok = clk_en && !sleep_request && slp_q == 4'h0;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // decoded starts and continues of a burst
    sequence wr_start;
        run_ok && !chip_select_n && proc_addr_strobe_n && !ctrl_addr_strobe_n
            && !(all_lanes_write_n && lane_write_enable_n);
    endsequence
    sequence any_start;
        run_ok && !chip_select_n && !(proc_addr_strobe_n && ctrl_addr_strobe_n);
    endsequence
    sequence cont_acc;
        run_ok && proc_addr_strobe_n && ctrl_addr_strobe_n && (mem_read || mem_lane_we != 0);
    endsequence
    gw_all_lanes_a: assert property (
        wr_start ##0 !all_lanes_write_n |=> mem_lane_we == {LANES{1'b1}} && !mem_read)
        else $error("global write lost a lane");
    lane_pick_a: assert property (
        wr_start ##0 all_lanes_write_n |=> mem_lane_we == ~$past(lane_select_n))
        else $error("lane writes differ from selects");
    read_start_a: assert property (
        run_ok && !chip_select_n && !proc_addr_strobe_n |=> mem_read && mem_lane_we == 0)
        else $error("processor strobe gave no read");
    new_addr_a: assert property (
        any_start |=> mem_addr == $past(addr_in))
        else $error("new address not loaded");
    hold_addr_a: assert property (
        cont_acc ##0 burst_step_n |=> mem_addr == $past(mem_addr))
        else $error("suspended burst moved");
    lin_step_a: assert property (
        cont_acc ##0 !burst_step_n && !linear_order_n && !$past(linear_order_n, 3)
        |=> mem_addr[1:0] == $past(mem_addr[1:0]) + 2'h1
        && mem_addr[AW-1:2] == $past(mem_addr[AW-1:2]))
        else $error("linear step wrong");
    oe_off_a: assert property (
        output_enable_n && $past(output_enable_n) && $past(output_enable_n, 2)
        && $past(output_enable_n, 3) |-> data_oe_n)
        else $error("pins driven with output enable high");
    sleep_idle_a: assert property (
        slp_q == 4'hF && sleep_request |-> standby && !mem_read && mem_lane_we == 0)
        else $error("activity during sleep");
endmodule
bind sbs_sram_control sbs_sram_control_sva #(.LANES(LANES), .AW(AW)) sbs_sram_control_sva_inst (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .chip_select_n(chip_select_n), .proc_addr_strobe_n(proc_addr_strobe_n),
    .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .burst_step_n(burst_step_n),
    .all_lanes_write_n(all_lanes_write_n), .lane_write_enable_n(lane_write_enable_n),
    .lane_select_n(lane_select_n), .addr_in(addr_in), .output_enable_n(output_enable_n),
    .sleep_request(sleep_request), .linear_order_n(linear_order_n), .data_oe_n(data_oe_n),
    .mem_addr(mem_addr), .mem_lane_we(mem_lane_we), .mem_read(mem_read), .standby(standby));

// ===== testbench/sbs_array_model.sv
// behavioural array behind the control block, feeding its read fifo
`timescale 1ns/1ps
module sbs_array_model #(
    parameter W  = 36,
    parameter AW = 8
) (
    input  logic          core_clk,
    input  logic [AW-1:0] mem_addr,
    input  logic [3:0]    mem_lane_we,
    input  logic          mem_read,
    input  logic [W-1:0]  data_in,
    input  logic          mem_rdata_ready,
    output logic          mem_rdata_valid,
    output logic [W-1:0]  mem_rdata
);
    logic [W-1:0] mem_q [0:(1<<AW)-1];
    logic [W-1:0] rd_q [$];
    initial begin
        mem_rdata_valid = 1'b0;
        mem_rdata = '0;
        foreach (mem_q[i]) mem_q[i] = '0;
    end
    // lanes land per strobe; reads queue and leave on valid and ready
    always @(posedge core_clk) begin
        for (int i = 0; i < 4; i++)
            if (mem_lane_we[i]) mem_q[mem_addr][i*9 +: 9] = data_in[i*9 +: 9];
        if (mem_rdata_valid && mem_rdata_ready) void'(rd_q.pop_front());
        if (mem_read) rd_q.push_back(mem_q[mem_addr]);
        #1;
        mem_rdata_valid = rd_q.size() != 0;
        // idle data flips each cycle so a stale word never passes
        mem_rdata = mem_rdata_valid ? rd_q[0] : ~mem_rdata;
    end
endmodule

// ===== testbench/sync_burst_sram_control_test.sv
// self-checking bench for the burst sram control block
`timescale 1ns/1ps
module sync_burst_sram_control_test;
    logic core_clk, reset_n, clk_en, chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n;
    logic burst_step_n, all_lanes_write_n, lane_write_enable_n, output_enable_n;
    logic sleep_request, register_bypass_n, linear_order_n, deselect_latency_sel;
    logic drive_strength_sel, mem_rdata_valid, mem_rdata_ready, data_oe_n, mem_read;
    logic standby, high_drive;
    logic [3:0]  lane_select_n, mem_lane_we;
    logic [7:0]  addr_in, mem_addr;
    logic [35:0] data_in, data_out, mem_rdata;
    int          err_total, total_checks, f1, c1, f2, c2, f3, c3;
    localparam logic [35:0] WORD0 = 36'h9A5C31E7B;
    sbs_sram_control sbs_sram_control_inst (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
        .chip_select_n(chip_select_n), .proc_addr_strobe_n(proc_addr_strobe_n),
        .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .burst_step_n(burst_step_n),
        .all_lanes_write_n(all_lanes_write_n), .lane_write_enable_n(lane_write_enable_n),
        .lane_select_n(lane_select_n), .addr_in(addr_in), .output_enable_n(output_enable_n),
        .sleep_request(sleep_request), .register_bypass_n(register_bypass_n),
        .linear_order_n(linear_order_n), .deselect_latency_sel(deselect_latency_sel),
        .drive_strength_sel(drive_strength_sel), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .mem_addr(mem_addr), .mem_lane_we(mem_lane_we),
        .mem_read(mem_read), .mem_rdata_valid(mem_rdata_valid),
        .mem_rdata_ready(mem_rdata_ready), .mem_rdata(mem_rdata), .standby(standby),
        .high_drive(high_drive));
    sbs_array_model sbs_array_model_inst (
        .core_clk(core_clk), .mem_addr(mem_addr), .mem_lane_we(mem_lane_we),
        .mem_read(mem_read), .data_in(data_in), .mem_rdata_ready(mem_rdata_ready),
        .mem_rdata_valid(mem_rdata_valid), .mem_rdata(mem_rdata));
    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one cycle: set at falling edge, return once the rising edge has landed
    task automatic drv(input logic [3:0] ctl, input logic [1:0] wr, input logic [3:0] sel,
                       input logic [7:0] a);
        @(negedge core_clk);
        {chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = ctl;
        {all_lanes_write_n, lane_write_enable_n} = wr;
        lane_select_n = sel;
        addr_in = a;
        @(posedge core_clk);
        #1;
    endtask
    // deselect cycles keep the pins quiet between scenarios
    task automatic idle(input int n);
        repeat (n) drv(4'hD, 2'b11, 4'hF, 8'h00);
    endtask
    task automatic strap(input logic byp_n, input logic lat, input logic oe_n);
        @(negedge core_clk);
        register_bypass_n = byp_n;
        deselect_latency_sel = lat;
        output_enable_n = oe_n;
        idle(5);
    endtask
    task automatic t_access();
        logic [3:0] sels [4] = '{4'hE, 4'h5, 4'h0, 4'hF};
        drv(4'h5, 2'b01, 4'hF, 8'h10);
        chk(mem_lane_we, 4'hF);
        chk(mem_addr, 8'h10);
        for (int i = 0; i < 4; i++) begin
            drv(4'h5, 2'b10, sels[i], 8'h20 + 8'(i));
            chk(mem_lane_we, 4'(~sels[i]));
        end
        drv(4'hD, 2'b01, 4'h0, 8'h40);
        chk({mem_read, mem_lane_we}, 5'h00);
        drv(4'h3, 2'b01, 4'h0, 8'h10);
        chk({mem_read, mem_lane_we}, 5'h10);
        drv(4'h5, 2'b11, 4'h0, 8'h10);
        chk({mem_read, mem_lane_we}, 5'h10);
        idle(6);
    endtask
    task automatic t_burst(input logic ilv);
        logic [1:0] lo;
        @(negedge core_clk);
        linear_order_n = ilv;
        idle(4);
        drv(4'h5, 2'b01, 4'hF, 8'h31);
        for (int k = 1; k <= 4; k++) begin
            drv(4'hE, 2'b01, 4'hF, 8'h00);
            lo = ilv ? (2'h1 ^ 2'(k)) : (2'h1 + 2'(k));
            chk(mem_addr, {6'h0C, lo});
            chk(data_oe_n, 1'b1);
        end
        drv(4'hF, 2'b01, 4'hF, 8'h00);
        chk(mem_addr, {6'h0C, lo});
        // clock enable low: a step request must not move the burst
        @(negedge core_clk);
        clk_en = 1'b0;
        drv(4'hE, 2'b01, 4'hF, 8'h00);
        chk(mem_addr, {6'h0C, lo});
        @(negedge core_clk);
        clk_en = 1'b1;
        idle(2);
    endtask
    // two-word read then deselects, noting when and how long pins drive
    task automatic rd_probe(output int first, output int cnt);
        first = 99;
        cnt = 0;
        drv(4'h5, 2'b11, 4'hF, 8'h10);
        drv(4'hE, 2'b11, 4'hF, 8'h00);
        chk(mem_addr, 8'h11);
        for (int j = 0; j < 10; j++) begin
            drv(4'hD, 2'b11, 4'hF, 8'h00);
            if (data_oe_n === 1'b0) begin
                if (cnt == 0) first = j;
                if (cnt == 0) chk(data_out, WORD0);
                cnt++;
            end
        end
    endtask
    task automatic t_modes();
        strap(1'b1, 1'b0, 1'b0);
        rd_probe(f1, c1);
        strap(1'b0, 1'b0, 1'b0);
        rd_probe(f2, c2);
        strap(1'b1, 1'b1, 1'b0);
        rd_probe(f3, c3);
        chk(f1, f2 + 1);
        chk(c1, c3 + 1);
        strap(1'b1, 1'b0, 1'b1);
        rd_probe(f2, c2);
        chk(c2, 0);
        strap(1'b1, 1'b1, 1'b0);
    endtask
    task automatic t_sleep();
        @(negedge core_clk);
        sleep_request = 1'b1;
        idle(4);
        drv(4'h5, 2'b01, 4'hF, 8'h50);
        chk({standby, mem_lane_we}, 5'h10);
        @(negedge core_clk);
        sleep_request = 1'b0;
        idle(4);
        chk(standby, 1'b0);
    endtask
    // main sequence: straps at defaults, reset ten cycles, then scenarios
    initial begin
        err_total = 0;
        total_checks = 0;
        {reset_n, clk_en, chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n} = 5'h0F;
        {burst_step_n, all_lanes_write_n, lane_write_enable_n, output_enable_n} = 4'hE;
        {sleep_request, register_bypass_n, linear_order_n} = 3'h3;
        {deselect_latency_sel, drive_strength_sel} = 2'h3;
        lane_select_n = 4'hF;
        addr_in = 8'h00;
        data_in = WORD0;
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
        idle(4);
        chk(standby, 1'b0);
        t_access();
        t_burst(1'b0);
        t_burst(1'b1);
        t_modes();
        t_sleep();
        complete_run();
    end
    // hang guard
    initial begin
        #4000000;
        err_total++;
        complete_run();
    end
endmodule
